// ==== can_crc15.sv ====
`timescale 1ns/1ns
module can_crc15 (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // bit stream
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic        bitIn,
  // remainder
  output logic [14:0]      crc,
  output logic [14:0]      crcNext
);

  logic [14:0] base;
  logic        fb;

  // =============================================================
  // serial divider, clear and first bit may share a cycle
  always_comb begin
    base    = clr ? can_fmt_pkg::CRC_INIT : crc;
    fb      = bitIn ^ base[14];
    crcNext = base;
    if (en) begin
      crcNext = {base[13:0], 1'b0} ^ (fb ? can_fmt_pkg::CRC_POLY : 15'h0000);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      crc <= can_fmt_pkg::CRC_INIT;
    end else begin
      crc <= crcNext;
    end
  end

endmodule : can_crc15

// ==== can_flag_seq.sv ====
`timescale 1ns/1ns
module can_flag_seq (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // bit strobe
  input  wire logic                   bitTick,
  input  wire logic                   rxBit,
  // control
  input  wire logic                   start,
  input  wire can_fmt_pkg::flagkind_t kind,
  input  wire logic                   passive,
  // status
  output logic                        busy,
  output logic                        flagBit,
  output logic                        done,
  output logic                        ovlReq,
  output logic                        formErr
);

  typedef enum logic [1:0] {F_IDLE, F_FLAG, F_WAIT, F_DELIM} flagst_t;

  flagst_t    st_r;
  logic [3:0] cnt_r;
  logic [3:0] run_r;

  assign busy = (st_r != F_IDLE);

  // =============================================================
  // flag, superimposed flags, delimiter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r    <= F_IDLE;
      cnt_r   <= 4'h0;
      run_r   <= 4'h0;
      flagBit <= can_fmt_pkg::REC;
      done    <= 1'b0;
      ovlReq  <= 1'b0;
      formErr <= 1'b0;
    end else begin
      done    <= 1'b0;
      ovlReq  <= 1'b0;
      formErr <= 1'b0;
      if (start) begin
        st_r    <= F_FLAG;
        cnt_r   <= 4'h0;
        run_r   <= 4'h0;
        flagBit <= (kind == can_fmt_pkg::FLAG_PASSIVE) ? can_fmt_pkg::REC
                                                       : can_fmt_pkg::DOM;
      end else if (bitTick) begin
        unique case (st_r)
          F_IDLE: begin
          end
          F_FLAG: begin
            run_r <= run_r + 4'h1;
            if (cnt_r == can_fmt_pkg::FLAG_BITS - 4'h1) begin
              st_r    <= F_WAIT;
              flagBit <= can_fmt_pkg::REC;
            end else begin
              cnt_r <= cnt_r + 4'h1;
            end
          end
          F_WAIT: begin
            // first recessive bit counts as delimiter bit one
            if (rxBit == can_fmt_pkg::REC) begin
              st_r  <= F_DELIM;
              cnt_r <= 4'h1;
            end else if (run_r == can_fmt_pkg::MAX_FLAG_BITS) begin
              formErr <= 1'b1;
              st_r    <= F_FLAG;
              cnt_r   <= 4'h0;
              run_r   <= 4'h0;
              flagBit <= passive ? can_fmt_pkg::REC : can_fmt_pkg::DOM;
            end else begin
              run_r <= run_r + 4'h1;
            end
          end
          F_DELIM: begin
            if (rxBit == can_fmt_pkg::DOM) begin
              st_r  <= F_FLAG;
              cnt_r <= 4'h0;
              run_r <= 4'h0;
              if (cnt_r == can_fmt_pkg::DELIM_BITS - 4'h1) begin
                // dominant last delimiter bit is an overload request
                ovlReq  <= 1'b1;
                flagBit <= can_fmt_pkg::DOM;
              end else begin
                formErr <= 1'b1;
                flagBit <= passive ? can_fmt_pkg::REC : can_fmt_pkg::DOM;
              end
            end else if (cnt_r == can_fmt_pkg::DELIM_BITS - 4'h1) begin
              st_r <= F_IDLE;
              done <= 1'b1;
            end else begin
              cnt_r <= cnt_r + 4'h1;
            end
          end
        endcase
      end
    end
  end

endmodule : can_flag_seq

// ==== can_fmt_chk.sv ====
`timescale 1ns/1ns
// ====
// port checks
module can_fmt_chk (
  // clock and reset
  input wire logic                clk,
  input wire logic                rst_b,
  // watched ports
  input wire logic                bitTick,
  input wire logic                txReq,
  input wire can_fmt_pkg::frame_t txFrame,
  input wire logic                txAccept,
  input wire logic                txRefused,
  input wire logic                txDone,
  input wire logic                txBusy,
  input wire logic                busOff,
  input wire logic                txBit
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence sofS;
    txAccept ##1 !txBit;
  endsequence
  refuse_level_a: assert property (txRefused == (txReq && txFrame.id[28:22] == 7'h7f))
    else $error("refuse level wrong");
  refuse_block_a: assert property (txRefused |-> !txAccept)
    else $error("refused id accepted");
  sof_first_a: assert property (txAccept |-> sofS)
    else $error("no dominant start bit");
  accept_cause_a: assert property (txAccept |-> bitTick && txReq && !busOff)
    else $error("accept without request");
  done_rec_a: assert property (txDone |-> txBit && $past(txBit))
    else $error("end bits not recessive");
  done_busy_a: assert property (txDone |-> $past(txBusy))
    else $error("done while not sending");
  reset_idle_a: assert property ($rose(rst_b) |-> txBit)
    else $error("bus not recessive in reset");
  busoff_rec_a: assert property (busOff && $past(busOff) |-> txBit)
    else $error("drives bus while off");
endmodule : can_fmt_chk
bind can_frame_format_engine can_fmt_chk chk_u (.clk, .rst_b, .bitTick, .txReq, .txFrame,
  .txAccept, .txRefused, .txDone, .txBusy, .busOff, .txBit);

// ==== can_fmt_pkg.sv ====
// =============================================================
// bus levels and field lengths
package can_fmt_pkg;

  localparam logic DOM = 1'b0;
  localparam logic REC = 1'b1;

  localparam logic [6:0] BASE_ID_BITS = 7'h0b;
  localparam logic [6:0] EXT_ID_BITS  = 7'h12;
  localparam logic [6:0] DLC_BITS     = 7'h04;
  localparam logic [6:0] CRC_BITS     = 7'h0f;
  localparam logic [6:0] EOF_BITS     = 7'h07;
  localparam logic [6:0] INTERM_BITS  = 7'h03;
  localparam logic [6:0] SUSPEND_BITS = 7'h08;

  localparam logic [3:0] FLAG_BITS      = 4'h6;
  localparam logic [3:0] DELIM_BITS     = 4'h8;
  localparam logic [3:0] MAX_FLAG_BITS  = 4'hc;
  localparam logic [3:0] MAX_DATA_BYTES = 4'h8;

  localparam logic [14:0] CRC_POLY = 15'h4599;
  localparam logic [14:0] CRC_INIT = 15'h0000;

  localparam logic [6:0] PROHIBITED_TOP7 = 7'h7f;

  localparam int ID_TOP   = 28;
  localparam int EXT_TOP  = 17;
  localparam int DLC_TOP  = 3;
  localparam int DATA_TOP = 63;
  localparam int CRC_TOP  = 14;

  // =============================================================
  // carriers
  typedef struct packed {
    logic [28:0] id;
    logic        ide;
    logic        rtr;
    logic [3:0]  dlc;
    logic [63:0] data;
  } frame_t;

  typedef struct packed {
    logic crc;
    logic form;
    logic ack;
    logic flagForm;
  } errev_t;

  typedef enum logic [1:0] {FLAG_ACTIVE, FLAG_PASSIVE, FLAG_OVERLOAD} flagkind_t;

endpackage : can_fmt_pkg

// ==== can_frame_format_engine.sv ====
`timescale 1ns/1ns
module can_frame_format_engine (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // destuffed bit stream at the sample point
  input  wire logic                bitTick,
  input  wire logic                rxBit,
  // transmit request
  input  wire logic                txReq,
  input  wire can_fmt_pkg::frame_t txFrame,
  output logic                     txAccept,
  output logic                     txRefused,
  output logic                     txDone,
  output logic                     txBusy,
  // node state and outside error logic
  input  wire logic                errPassive,
  input  wire logic                busOff,
  input  wire logic                sleepMode,
  input  wire logic                errDetect,
  input  wire logic                arbLost,
  // bus output
  output logic                     txBit,
  // receive result
  output can_fmt_pkg::frame_t      rxFrame,
  output logic                     rxValid,
  output can_fmt_pkg::errev_t      errEvent
);

  typedef enum logic [4:0] {
    ST_IDLE, ST_SOF, ST_BASEID, ST_SRR_RTR, ST_IDE, ST_EXTID, ST_RTR_EXT,
    ST_RES1, ST_RES0, ST_DLC, ST_DATA, ST_CRC, ST_CRCDEL, ST_ACKSLOT,
    ST_ACKDEL, ST_EOF, ST_INTERM, ST_SUSPEND, ST_FLAGS
  } fmtstate_t;

  fmtstate_t              state_r;
  fmtstate_t              state_nxt;
  logic [6:0]             cnt_r;
  logic [6:0]             cnt_nxt;
  logic                   txActive_r;
  logic                   txActive_nxt;
  can_fmt_pkg::frame_t    txFrm_r;
  can_fmt_pkg::frame_t    rxFrm_r;
  logic [14:0]            rxCrc_r;
  logic                   crcErr_r;
  logic                   suspendPend_r;
  logic                   txBit_r;
  can_fmt_pkg::errev_t    ev_r;
  can_fmt_pkg::errev_t    ev_nxt;
  logic                   startTx;
  logic                   sofRx;
  logic                   ovlNow;
  logic                   errAny;
  logic                   crcMis;
  logic                   prohibited;
  logic                   txGo;
  logic                   atLast;
  logic                   ackOk;
  logic                   crcEn;
  logic [14:0]            crcVal;
  logic [14:0]            crcNext;
  logic                   flagBusy;
  logic                   flagBit;
  logic                   flagDone;
  logic                   flagForm;
  logic                   flagStart;
  can_fmt_pkg::flagkind_t flagKind;

  // =============================================================
  // helpers
  function automatic logic [3:0] dlcBytes(input logic [3:0] dlc);
    return dlc[3] ? can_fmt_pkg::MAX_DATA_BYTES : {1'b0, dlc[2:0]};
  endfunction : dlcBytes

  function automatic logic [6:0] lastIndex(input fmtstate_t s, input logic [3:0] bytes);
    logic [6:0] l;
    l = 7'h00;
    case (s)
      ST_BASEID:  l = can_fmt_pkg::BASE_ID_BITS - 7'h01;
      ST_EXTID:   l = can_fmt_pkg::EXT_ID_BITS - 7'h01;
      ST_DLC:     l = can_fmt_pkg::DLC_BITS - 7'h01;
      ST_DATA:    l = {bytes - 4'h1, 3'h7};
      ST_CRC:     l = can_fmt_pkg::CRC_BITS - 7'h01;
      ST_EOF:     l = can_fmt_pkg::EOF_BITS - 7'h01;
      ST_INTERM:  l = can_fmt_pkg::INTERM_BITS - 7'h01;
      ST_SUSPEND: l = can_fmt_pkg::SUSPEND_BITS - 7'h01;
      default:    l = 7'h00;
    endcase
    return l;
  endfunction : lastIndex

  // level that the transmitter puts on the bus for one field bit
  function automatic logic txValue(input fmtstate_t s, input logic [6:0] c,
                                   input can_fmt_pkg::frame_t f, input logic [14:0] crc);
    logic b;
    b = can_fmt_pkg::REC;
    unique case (s)
      ST_SOF:     b = can_fmt_pkg::DOM;
      ST_BASEID:  b = f.id[can_fmt_pkg::ID_TOP - int'(c)];
      ST_SRR_RTR: b = f.ide ? can_fmt_pkg::REC : f.rtr;
      ST_IDE:     b = f.ide;
      ST_EXTID:   b = f.id[can_fmt_pkg::EXT_TOP - int'(c)];
      ST_RTR_EXT: b = f.rtr;
      ST_RES1:    b = can_fmt_pkg::DOM;
      ST_RES0:    b = can_fmt_pkg::DOM;
      ST_DLC:     b = f.dlc[can_fmt_pkg::DLC_TOP - int'(c)];
      ST_DATA:    b = f.data[can_fmt_pkg::DATA_TOP - int'(c)];
      ST_CRC:     b = crc[can_fmt_pkg::CRC_TOP - int'(c)];
      default:    b = can_fmt_pkg::REC;
    endcase
    return b;
  endfunction : txValue

  assign prohibited = (txFrame.id[28:22] == can_fmt_pkg::PROHIBITED_TOP7);
  assign txGo       = txReq && !prohibited && !busOff && !sleepMode;
  assign txRefused  = txReq && prohibited;
  assign txAccept   = startTx;
  assign txBusy     = txActive_r;
  assign atLast     = (cnt_r == lastIndex(state_r, dlcBytes(rxFrm_r.dlc)));
  assign ackOk      = !txActive_r && !crcErr_r && !busOff && !sleepMode;

  // =============================================================
  // field sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    startTx   = 1'b0;
    sofRx     = 1'b0;
    ovlNow    = 1'b0;
    ev_nxt    = '0;
    crcMis    = 1'b0;
    if (bitTick) begin
      cnt_nxt = cnt_r + 7'h01;
      unique case (state_r)
        ST_IDLE: begin
          if (txGo) begin
            state_nxt = ST_SOF;
            startTx   = 1'b1;
          end else if (rxBit == can_fmt_pkg::DOM) begin
            state_nxt = ST_BASEID;
            sofRx     = 1'b1;
          end
        end
        ST_SOF:     state_nxt = ST_BASEID;
        ST_BASEID:  if (atLast) state_nxt = ST_SRR_RTR;
        ST_SRR_RTR: state_nxt = ST_IDE;
        ST_IDE:     state_nxt = (rxBit == can_fmt_pkg::REC) ? ST_EXTID : ST_RES0;
        ST_EXTID:   if (atLast) state_nxt = ST_RTR_EXT;
        ST_RTR_EXT: state_nxt = ST_RES1;
        ST_RES1:    state_nxt = ST_RES0;
        ST_RES0:    state_nxt = ST_DLC;
        ST_DLC: begin
          if (atLast) begin
            // remote frames and zero length skip the data field
            if (rxFrm_r.rtr || dlcBytes({rxFrm_r.dlc[3:1], rxBit}) == 4'h0) begin
              state_nxt = ST_CRC;
            end else begin
              state_nxt = ST_DATA;
            end
          end
        end
        ST_DATA: if (atLast) state_nxt = ST_CRC;
        ST_CRC: begin
          if (atLast) begin
            state_nxt = ST_CRCDEL;
            crcMis    = ({rxCrc_r[13:0], rxBit} != crcVal);
          end
        end
        ST_CRCDEL: begin
          if (rxBit == can_fmt_pkg::DOM) ev_nxt.form = 1'b1;
          else state_nxt = ST_ACKSLOT;
        end
        ST_ACKSLOT: begin
          if (txActive_r && rxBit == can_fmt_pkg::REC) ev_nxt.ack = 1'b1;
          else state_nxt = ST_ACKDEL;
        end
        ST_ACKDEL: begin
          // crc error is flagged only after the ack delimiter
          if (rxBit == can_fmt_pkg::DOM) ev_nxt.form = 1'b1;
          else if (crcErr_r) ev_nxt.crc = 1'b1;
          else state_nxt = ST_EOF;
        end
        ST_EOF: begin
          if (rxBit == can_fmt_pkg::DOM) begin
            if (atLast && !txActive_r) ovlNow = 1'b1;
            else ev_nxt.form = 1'b1;
          end else if (atLast) begin
            state_nxt = ST_INTERM;
          end
        end
        ST_INTERM: begin
          if (rxBit == can_fmt_pkg::DOM) begin
            if (!atLast) begin
              ovlNow = 1'b1;
            end else begin
              state_nxt = ST_BASEID;
              sofRx     = 1'b1;
            end
          end else if (atLast) begin
            if (suspendPend_r) begin
              state_nxt = ST_SUSPEND;
            end else if (txGo) begin
              state_nxt = ST_SOF;
              startTx   = 1'b1;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        ST_SUSPEND: begin
          if (rxBit == can_fmt_pkg::DOM) begin
            state_nxt = ST_BASEID;
            sofRx     = 1'b1;
          end else if (atLast) begin
            if (txGo) begin
              state_nxt = ST_SOF;
              startTx   = 1'b1;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        ST_FLAGS: begin
        end
        default: state_nxt = ST_IDLE;
      endcase
      if (state_nxt != state_r) cnt_nxt = 7'h00;
    end
    errAny = ev_nxt.form || ev_nxt.ack || ev_nxt.crc ||
             (bitTick && errDetect && state_r != ST_IDLE && state_r != ST_FLAGS);
    if (errAny || ovlNow) begin
      // no interframe space before error or overload frames
      state_nxt = ST_FLAGS;
      cnt_nxt   = 7'h00;
      startTx   = 1'b0;
      sofRx     = 1'b0;
    end
    if (state_r == ST_FLAGS && flagDone) begin
      state_nxt = ST_INTERM;
      cnt_nxt   = 7'h00;
    end
    ev_nxt.flagForm = flagForm;
  end

  always_comb begin
    txActive_nxt = txActive_r;
    if (startTx) begin
      txActive_nxt = 1'b1;
    end else if (bitTick && (arbLost || state_nxt == ST_FLAGS ||
                             (state_r == ST_EOF && state_nxt == ST_INTERM))) begin
      txActive_nxt = 1'b0;
    end
  end

  assign flagStart = errAny || ovlNow;
  assign flagKind  = errAny ? (errPassive ? can_fmt_pkg::FLAG_PASSIVE
                                          : can_fmt_pkg::FLAG_ACTIVE)
                            : can_fmt_pkg::FLAG_OVERLOAD;
  assign crcEn     = bitTick && (sofRx || state_r inside {ST_SOF, ST_BASEID, ST_SRR_RTR,
                     ST_IDE, ST_EXTID, ST_RTR_EXT, ST_RES1, ST_RES0, ST_DLC, ST_DATA});

  // =============================================================
  // state, role and frame latches
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r    <= ST_IDLE;
      cnt_r      <= 7'h00;
      txActive_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      txActive_r <= txActive_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txFrm_r <= '0;
    end else if (startTx) begin
      txFrm_r <= txFrame;
    end
  end

  // =============================================================
  // receive capture, both roles read the bus back
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxFrm_r <= '0;
      rxCrc_r <= 15'h0000;
    end else if (startTx || sofRx) begin
      rxFrm_r <= '0;
      rxCrc_r <= 15'h0000;
    end else if (bitTick) begin
      unique case (state_r)
        ST_BASEID:  rxFrm_r.id[can_fmt_pkg::ID_TOP - int'(cnt_r)]  <= rxBit;
        ST_EXTID:   rxFrm_r.id[can_fmt_pkg::EXT_TOP - int'(cnt_r)] <= rxBit;
        ST_SRR_RTR: rxFrm_r.rtr <= rxBit;
        ST_RTR_EXT: rxFrm_r.rtr <= rxBit;
        ST_IDE:     rxFrm_r.ide <= rxBit;
        ST_DLC:     rxFrm_r.dlc[can_fmt_pkg::DLC_TOP - int'(cnt_r)] <= rxBit;
        ST_DATA:    rxFrm_r.data[can_fmt_pkg::DATA_TOP - int'(cnt_r)] <= rxBit;
        ST_CRC:     rxCrc_r <= {rxCrc_r[13:0], rxBit};
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      crcErr_r <= 1'b0;
    end else if (startTx || sofRx) begin
      crcErr_r <= 1'b0;
    end else if (crcMis && !txActive_r) begin
      crcErr_r <= 1'b1;
    end
  end

  // frame counts as received at the sixth end-of-frame bit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxFrame <= '0;
      rxValid <= 1'b0;
      txDone  <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      txDone  <= 1'b0;
      if (bitTick && state_r == ST_EOF && rxBit == can_fmt_pkg::REC) begin
        if (!txActive_r && cnt_r == can_fmt_pkg::EOF_BITS - 7'h02) begin
          rxFrame <= rxFrm_r;
          rxValid <= 1'b1;
        end
        if (txActive_r && atLast) txDone <= 1'b1;
      end
    end
  end

  // set wins over the clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      suspendPend_r <= 1'b0;
    end else if (txActive_r && !txActive_nxt && !arbLost && errPassive) begin
      suspendPend_r <= 1'b1;
    end else if (state_nxt == ST_SUSPEND) begin
      suspendPend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ev_r <= '0;
    end else begin
      ev_r <= ev_nxt;
    end
  end

  assign errEvent = ev_r;

  // =============================================================
  // next bus level, ready one sample point ahead
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txBit_r <= can_fmt_pkg::REC;
    end else if (bitTick) begin
      if (state_nxt == ST_FLAGS) begin
        txBit_r <= can_fmt_pkg::REC;
      end else if (txActive_nxt && state_nxt inside {ST_SOF, ST_BASEID, ST_SRR_RTR, ST_IDE,
                   ST_EXTID, ST_RTR_EXT, ST_RES1, ST_RES0, ST_DLC, ST_DATA, ST_CRC}) begin
        txBit_r <= txValue(state_nxt, cnt_nxt, txFrm_r, crcNext);
      end else if (state_nxt == ST_ACKSLOT && ackOk) begin
        txBit_r <= can_fmt_pkg::DOM;
      end else begin
        txBit_r <= can_fmt_pkg::REC;
      end
    end
  end

  // a node that is off the bus or asleep never drives dominant
  assign txBit = (busOff || sleepMode) ? can_fmt_pkg::REC
                                       : (flagBusy ? flagBit : txBit_r);

  // =============================================================
  // submodules
  can_crc15 u_crc (
    .clk     (clk),
    .rst_b   (rst_b),
    .clr     (startTx || sofRx),
    .en      (crcEn),
    .bitIn   (rxBit),
    .crc     (crcVal),
    .crcNext (crcNext)
  );

  can_flag_seq u_flag (
    .clk     (clk),
    .rst_b   (rst_b),
    .bitTick (bitTick),
    .rxBit   (rxBit),
    .start   (flagStart),
    .kind    (flagKind),
    .passive (errPassive),
    .busy    (flagBusy),
    .flagBit (flagBit),
    .done    (flagDone),
    .ovlReq  (),
    .formErr (flagForm)
  );

endmodule : can_frame_format_engine

// ==== can_frame_format_engine_bench.sv ====
`timescale 1ns/1ns
module can_frame_format_engine_bench;
  // ====
  // stimulus and wiring
  logic clk = 1'b0, rst_b = 1'b0, bitTick = 1'b0, txReq = 1'b0, errPassive = 1'b0;
  logic busOff = 1'b0, errDetect = 1'b0, ackDom = 1'b0, sleepMode = 1'b0, acc = 1'b0;
  logic arbLost = 1'b0;
  logic rxBit, txAccept, txRefused, txDone, txBusy, txBit, rxValid;
  can_fmt_pkg::frame_t txFrame = '0;
  can_fmt_pkg::frame_t rxFrame;
  can_fmt_pkg::errev_t errEvent;
  int fails = 0;
  int n_tests = 0;
  int nDone = 0, nRx = 0, nCrc = 0;
  logic q[$];
  always #10 clk = ~clk;
  // pulses last one clock; count them so a scenario can look after the fact
  always @(posedge clk) begin
    nDone <= nDone + txDone;
    nRx   <= nRx + rxValid;
    nCrc  <= nCrc + errEvent.crc;
  end
  can_frame_format_engine dut_u (.clk, .rst_b, .bitTick, .rxBit, .txReq, .txFrame, .txAccept,
    .txRefused, .txDone, .txBusy, .errPassive, .busOff, .sleepMode, .errDetect,
    .arbLost, .txBit, .rxFrame, .rxValid, .errEvent);
  can_node_model node_u (.txBit, .ackDom, .rxBit);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  // one bit time is three clocks; accept is combinational, so read it mid-tick
  task automatic tick();
    @(negedge clk) bitTick = 1'b1;
    #1 acc = txAccept;
    @(negedge clk) bitTick = 1'b0;
    @(negedge clk);
  endtask : tick
  task automatic start();
    txReq = 1'b1;
    acc = 1'b0;
    for (int k = 0; k < 40 && !acc; k++) tick();
    check("accept", acc, 1'b1);
    txReq = 1'b0;
  endtask : start
  task automatic build(input can_fmt_pkg::frame_t f, output int ack);
    logic [14:0] c;
    int n;
    q = {};
    c = 15'h0000;
    n = f.rtr ? 0 : (f.dlc[3] ? 8 : f.dlc);
    q.push_back(1'b0);
    for (int i = 28; i >= 18; i--) q.push_back(f.id[i]);
    if (f.ide) begin
      q.push_back(1'b1);
      q.push_back(1'b1);
      for (int i = 17; i >= 0; i--) q.push_back(f.id[i]);
    end
    q.push_back(f.rtr);
    q.push_back(1'b0);
    q.push_back(1'b0);
    for (int i = 3; i >= 0; i--) q.push_back(f.dlc[i]);
    for (int i = 63; i > 63 - 8 * n; i--) q.push_back(f.data[i]);
    foreach (q[i]) c = {c[13:0], 1'b0} ^ ((q[i] ^ c[14]) ? 15'h4599 : 15'h0000);
    for (int i = 14; i >= 0; i--) q.push_back(c[i]);
    ack = q.size() + 1;
    repeat (13) q.push_back(1'b1);
  endtask : build
  task automatic send(input can_fmt_pkg::frame_t f);
    int ack;
    int d0;
    build(f, ack);
    txFrame = f;
    d0 = nDone;
    start();
    foreach (q[i]) begin
      check("txBit", txBit, q[i]);
      ackDom = (i == ack);
      tick();
    end
    ackDom = 1'b0;
    check("done", nDone - d0, 1);
    $display("frame test done");
  endtask : send
  // far node sends the frame; bad flips the last crc bit
  task automatic recv(input can_fmt_pkg::frame_t f, input logic bad);
    int ack;
    int r0;
    int e0;
    build(f, ack);
    if (bad) q[ack - 2] = ~q[ack - 2];
    r0 = nRx;
    e0 = nCrc;
    foreach (q[i]) begin
      if (i == ack) check("ack slot", txBit, bad);
      ackDom = ~q[i];
      tick();
    end
    ackDom = 1'b0;
    repeat (10) tick();
    check("rx valid", nRx - r0, !bad);
    check("crc error", nCrc - e0, bad);
    check("rx id", rxFrame.id, f.id);
    check("rx ctrl", {rxFrame.ide, rxFrame.rtr, rxFrame.dlc}, {f.ide, f.rtr, f.dlc});
    check("rx data", rxFrame.data[31:0], f.data[31:0]);
    $display("receive test done");
  endtask : recv
  task automatic refuse();
    txFrame = '0;
    txFrame.id = 29'h1fc00000;
    txReq = 1'b1;
    tick();
    check("refused", txRefused, 1'b1);
    check("accept", acc, 1'b0);
    txFrame.id = 29'h00400000;
    for (int m = 0; m < 2; m++) begin
      busOff = (m == 0);
      sleepMode = (m == 1);
      tick();
      check("off accept", acc, 1'b0);
      check("off bit", txBit, 1'b1);
    end
    busOff = 1'b0;
    sleepMode = 1'b0;
    txReq = 1'b0;
    $display("refuse test done");
  endtask : refuse
  task automatic errFlag(input logic pas);
    int n;
    errPassive = pas;
    txFrame = '0;
    txFrame.id = 29'h03fc0000;
    start();
    repeat (4) tick();
    // active run drops the sender role first, so no suspend is owed
    arbLost = !pas;
    tick();
    arbLost = 1'b0;
    check("lost busy", txBusy, pas);
    errDetect = 1'b1;
    tick();
    errDetect = 1'b0;
    for (int k = 0; k < 13; k++) begin
      check("flag", txBit, k < 6 ? pas : 1'b1);
      tick();
    end
    txReq = 1'b1;
    for (n = 1; n < 20; n++) begin
      tick();
      if (acc) break;
    end
    txReq = 1'b0;
    check("resume", n, pas ? 12 : 4);
    errDetect = 1'b1;
    tick();
    errDetect = 1'b0;
    repeat (30) tick();
    errPassive = 1'b0;
    $display("error flag test done");
  endtask : errFlag
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    send({29'h12340000, 1'b0, 1'b0, 4'h2, 64'hc3a5000000000000});
    send({29'h0abcdef1, 1'b1, 1'b0, 4'hf, 64'h0123456789abcdef});
    send({29'h15555555, 1'b1, 1'b1, 4'h3, 64'h0});
    recv({29'h0a5c0000, 1'b0, 1'b0, 4'h8, 64'h5a0ff00f12345678}, 1'b0);
    recv({29'h0a5c0000, 1'b0, 1'b0, 4'h8, 64'h5a0ff00f12345678}, 1'b1);
    refuse();
    errFlag(1'b0);
    errFlag(1'b1);
    conclude();
  end
  // about 650 bit times of three clocks; allow several times that
  initial begin
    #200000;
    fails++;
    conclude();
  end
endmodule : can_frame_format_engine_bench

// ==== can_node_model.sv ====
`timescale 1ns/1ns
// ====
// far node: open-collector bus, pulls the bus dominant whenever ackDom is set
module can_node_model (
  // bus
  input  wire logic txBit,
  input  wire logic ackDom,
  output logic      rxBit
);
  // wired-and: dominant wins
  assign rxBit = txBit & ~ackDom;
endmodule : can_node_model
